/* File: adcs_pkg.sv */
// Shared constants and types for the converter track/hold sequencer
package adcs_pkg;
   // Timing: internal oscillator period and the system clock period
   localparam int OSC_PERIOD_NS = 250;
   localparam int CLK_PERIOD_NS = 40;
   // Longest whole number of system cycles per oscillator cycle, never below one
   localparam int OSC_DIV = (OSC_PERIOD_NS / CLK_PERIOD_NS) < 1 ? 1 : (OSC_PERIOD_NS / CLK_PERIOD_NS);
   // Falling serial-clock edge positions within the address byte
   localparam logic [3:0] INT_TRACK_FALL = 4'h9;
   localparam logic [3:0] EXT_TRACK_FALL = 4'h7;
   localparam logic [3:0] EXT_HOLD_FALL = 4'h8;
   localparam logic [3:0] FALL_MAX = 4'hf;
   // Acquisition length in internal oscillator cycles
   localparam logic [1:0] ACQ_OSC_CYCLES = 2'h2;
   localparam int SAR_BITS = 8;
   localparam int MAX_CH = 12;
   localparam int NUM_CH_DEF = 12;
   // Bipolar results flip the top bit of the offset-binary code
   localparam logic [7:0] BIP_FLIP = 8'h80;
   // Reference select bit that hands the shared pin to the reference
   localparam int REF_PIN_SEL_BIT = 1;

   typedef struct packed {
      logic ext_clock;
      logic single_ended_select;
      logic bipolar_select;
      logic [2:0] ref_sel;
      logic [3:0] channel_sel;
      logic [3:0] scan_count;
   } adcs_cfg_t;

   typedef struct packed {
      logic [MAX_CH-1:0] pos;
      logic [MAX_CH-1:0] neg;
      logic neg_gnd;
      logic shared_pin_is_ref;
   } adcs_mux_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_TRACK = 3'b010,
      ST_CONV = 3'b100
   } adcs_state_t;
endpackage

/* File: adcs_sar.sv */
// Successive-approximation register: one decision per conversion clock
`timescale 1ns/10ps
module adcs_sar import adcs_pkg::*; #(
   parameter int BITS = SAR_BITS
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic step,
   input wire logic cmp_high,
   // Results
   output logic [BITS-1:0] trial,
   output logic [BITS-1:0] code,
   output logic done
);
   logic [BITS-1:0] mask_reg;
   logic busy_reg;

   // Keep or drop the trial bit, then try the next lower one
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         trial <= '0;
         mask_reg <= '0;
         busy_reg <= 1'b0;
         code <= '0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            trial <= {1'b1, {(BITS-1){1'b0}}};
            mask_reg <= {1'b1, {(BITS-1){1'b0}}};
            busy_reg <= 1'b1;
         end else if (step && busy_reg) begin
            trial <= (cmp_high ? trial : (trial & ~mask_reg)) | (mask_reg >> 1);
            mask_reg <= mask_reg >> 1;
            if (mask_reg[0]) begin
               code <= cmp_high ? trial : (trial & ~mask_reg);
               busy_reg <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

   // Count decisions since start so the result is tied to exactly BITS steps
   logic [4:0] chk_steps;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) chk_steps <= '0;
      else if (start) chk_steps <= '0;
      else if (step && busy_reg) chk_steps <= chk_steps + 5'h1;
   end

   property p_sar_bits;
      @(posedge clock) disable iff (rst) done |-> chk_steps == 5'(BITS);
   endproperty
   a_sar_bits: assert property (p_sar_bits) else $error("result ready after wrong step count");
endmodule // adcs_sar

/* File: adcs_seq.sv */
// Track/hold, conversion sequencing and input routing of the converter
`timescale 1ns/10ps
// How it works
// - Internal clock: track on ninth address fall
// - Internal clock: hold two oscillator cycles later
// - Internal: eight oscillator cycles per conversion, clock low
// - External clock: track on seventh fall, matched
// - External clock: hold on eighth fall
// - External: convert over next eight clock cycles
// - Acquisition: two oscillator cycles, one bus period
// - Eight-bit successive approximation, one bit/cycle
// - Single-ended: selected input, referenced to ground
// - Pseudo-differential: pair positive, negative as reference
// - Shared pin role follows reference selection
// - Channel count 4, 8 or 12; decode limited
// - Select one means single-ended, zero pairs
// - External mode: bus clock is conversion clock
// - Straight binary unipolar and single-ended, two's complement bipolar pairs
module adcs_seq import adcs_pkg::*; #(
   parameter int NUM_CH = NUM_CH_DEF
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Serial clock pin, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   // From the serial protocol logic
   input wire logic addr_start,
   input wire logic addr_match,
   input wire adcs_cfg_t cfg,
   // Analog front end
   input wire logic cmp_high,
   output logic [SAR_BITS-1:0] dac_trial,
   output logic track,
   output adcs_mux_t mux,
   // Results
   output logic [SAR_BITS-1:0] result,
   output logic result_valid,
   output logic busy
);
   adcs_state_t state_reg;
   logic scl_s1, scl_s2, scl_s3, scl_level, scl_fall;
   logic [3:0] fall_cnt;
   logic [7:0] osc_div_cnt;
   logic osc_tick;
   logic [1:0] acq_cnt;
   logic [3:0] conv_left;
   logic sar_start, sar_step, sar_done;
   logic [SAR_BITS-1:0] sar_code;

   // Three-stage sampler on the pin; s1 feeds only s2
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         scl_level <= 1'b1;
      end else begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         if (scl_s2 == scl_s3) scl_level <= scl_s3;
      end
   end
   assign scl_fall = scl_level && !scl_s2 && !scl_s3;

   // Falling edges since the start of the address byte, saturating
   always_ff @(posedge clock or posedge rst) begin
      if (rst) fall_cnt <= '0;
      else if (addr_start) fall_cnt <= '0;
      else if (scl_fall && fall_cnt != FALL_MAX) fall_cnt <= fall_cnt + 4'h1;
   end

   // Internal oscillator stand-in: a one-cycle enable, only runs while busy
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         osc_div_cnt <= '0;
         osc_tick <= 1'b0;
      end else if (state_reg == ST_IDLE || cfg.ext_clock) begin
         osc_div_cnt <= '0;
         osc_tick <= 1'b0;
      end else if (osc_div_cnt == 8'(OSC_DIV - 1)) begin
         osc_div_cnt <= '0;
         osc_tick <= 1'b1;
      end else begin
         osc_div_cnt <= osc_div_cnt + 8'h1;
         osc_tick <= 1'b0;
      end
   end

   // Conversion clock: bus falls in external mode, oscillator otherwise
   assign sar_step = (state_reg == ST_CONV) && (cfg.ext_clock ? scl_fall : osc_tick);
   assign sar_start = (state_reg != ST_CONV) && (cfg.ext_clock ? (state_reg == ST_TRACK && scl_fall)
                                                              : (state_reg == ST_TRACK && osc_tick
                                                                 && acq_cnt == ACQ_OSC_CYCLES - 2'h1));

   // Sequencer: idle, acquire, convert; an internal-clock scan repeats acquire and convert
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         acq_cnt <= '0;
         conv_left <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               acq_cnt <= '0;
               conv_left <= (cfg.scan_count == 4'h0) ? 4'h1 : cfg.scan_count;
               if (!cfg.ext_clock && scl_fall && fall_cnt == INT_TRACK_FALL - 4'h1) begin
                  state_reg <= ST_TRACK;
               end else if (cfg.ext_clock && scl_fall && addr_match
                            && fall_cnt == EXT_TRACK_FALL - 4'h1) begin
                  state_reg <= ST_TRACK;
               end
            end
            ST_TRACK: begin
               if (osc_tick) acq_cnt <= acq_cnt + 2'h1;
               if (sar_start) begin
                  state_reg <= ST_CONV;
                  acq_cnt <= '0;
               end
            end
            ST_CONV: begin
               if (sar_done) begin
                  conv_left <= conv_left - 4'h1;
                  // External mode makes one conversion per address byte
                  state_reg <= (!cfg.ext_clock && conv_left != 4'h1) ? ST_TRACK : ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   adcs_sar #(.BITS(SAR_BITS)) i_adcs_sar (
      .clock(clock),
      .rst(rst),
      .start(sar_start),
      .step(sar_step),
      .cmp_high(cmp_high),
      .trial(dac_trial),
      .code(sar_code),
      .done(sar_done)
   );

   // Track switch and clock stretch start one cycle after the state, and end on the same edge the state moves on
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         track <= 1'b0;
         scl_out <= 1'b0;
         scl_oe_n <= 1'b1;
         busy <= 1'b0;
      end else begin
         track <= (state_reg == ST_TRACK) && !sar_start;
         scl_out <= 1'b0;
         // Internal clock only: stretching from the first track until the last result is out
         scl_oe_n <= cfg.ext_clock || state_reg == ST_IDLE || (sar_done && conv_left == 4'h1);
         busy <= state_reg != ST_IDLE;
      end
   end

   // Result coding: bipolar only applies to paired inputs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         result <= '0;
         result_valid <= 1'b0;
      end else begin
         result_valid <= sar_done;
         if (sar_done) begin
            result <= (cfg.bipolar_select && !cfg.single_ended_select) ? (sar_code ^ BIP_FLIP) : sar_code;
         end
      end
   end

   // Input routing; channel switches frozen during conversion, shared pin role follows ref_sel every cycle
   logic shared_ref;
   logic [3:0] neg_idx;
   logic ch_ok;
   assign shared_ref = cfg.ref_sel[REF_PIN_SEL_BIT];
   assign neg_idx = cfg.channel_sel ^ 4'h1;
   assign ch_ok = (32'(cfg.channel_sel) < NUM_CH)
                  && !(shared_ref && 32'(cfg.channel_sel) == NUM_CH - 1)
                  && (cfg.single_ended_select || !(shared_ref && 32'(neg_idx) == NUM_CH - 1));

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mux <= '0;
      end else begin
         mux.shared_pin_is_ref <= shared_ref;
         if (state_reg != ST_CONV) begin
            mux.neg_gnd <= cfg.single_ended_select;
            for (int i = 0; i < MAX_CH; i++) begin
               mux.pos[i] <= ch_ok && i < NUM_CH && 4'(i) == cfg.channel_sel;
               mux.neg[i] <= ch_ok && i < NUM_CH && !cfg.single_ended_select && 4'(i) == neg_idx;
            end
         end
      end
   end

   property p_int_track;
      @(posedge clock) disable iff (rst)
      (state_reg == ST_IDLE && !cfg.ext_clock && scl_fall && fall_cnt == 4'h8) |=> state_reg == ST_TRACK ##1 track;
   endproperty
   a_int_track: assert property (p_int_track) else $error("no track on ninth fall");

   // Longest acquisition: two whole oscillator periods plus the registered tick
   localparam int ACQ_WAIT_MAX = 2 * OSC_DIV + 1;
   property p_int_acq;
      @(posedge clock) disable iff (rst)
      ($rose(state_reg == ST_TRACK) && !cfg.ext_clock) |-> acq_cnt == 2'h0 ##[1:ACQ_WAIT_MAX] state_reg == ST_CONV;
   endproperty
   a_int_acq: assert property (p_int_acq) else $error("acquisition not ended in time");

   // Acquisition counted in oscillator ticks at the moment of hold
   property p_int_hold;
      @(posedge clock) disable iff (rst)
      (state_reg == ST_TRACK && !cfg.ext_clock && sar_start) |-> osc_tick && acq_cnt == 2'h1;
   endproperty
   a_int_hold: assert property (p_int_hold) else $error("hold not after two oscillator cycles");

   property p_int_stretch;
      @(posedge clock) disable iff (rst)
      (state_reg == ST_CONV && !cfg.ext_clock && !sar_done) |=> !scl_oe_n;
   endproperty
   a_int_stretch: assert property (p_int_stretch) else $error("clock line released mid conversion");

   property p_ext_track;
      @(posedge clock) disable iff (rst)
      (state_reg == ST_IDLE && cfg.ext_clock && addr_match && scl_fall && fall_cnt == 4'h6) |=> state_reg == ST_TRACK;
   endproperty
   a_ext_track: assert property (p_ext_track) else $error("no track on seventh fall");

   property p_ext_hold;
      @(posedge clock) disable iff (rst)
      (state_reg == ST_TRACK && cfg.ext_clock && scl_fall) |=> state_reg == ST_CONV ##1 !track;
   endproperty
   a_ext_hold: assert property (p_ext_hold) else $error("no hold on eighth fall");

   property p_ext_step;
      @(posedge clock) disable iff (rst)
      (state_reg == ST_CONV && cfg.ext_clock) |-> sar_step == scl_fall;
   endproperty
   a_ext_step: assert property (p_ext_step) else $error("conversion not clocked by bus clock");

   property p_release;
      @(posedge clock) disable iff (rst)
      ($rose(scl_oe_n) && !cfg.ext_clock) |-> result_valid;
   endproperty
   a_release: assert property (p_release) else $error("clock released before result");

   property p_code;
      @(posedge clock) disable iff (rst)
      result_valid |-> result == (($past(cfg.bipolar_select) && !$past(cfg.single_ended_select))
                                  ? ($past(sar_code) ^ BIP_FLIP) : $past(sar_code));
   endproperty
   a_code: assert property (p_code) else $error("wrong result coding");

   property p_mux_range;
      @(posedge clock) disable iff (rst)
      (state_reg != ST_CONV && 32'(cfg.channel_sel) >= NUM_CH) |=> mux.pos == '0;
   endproperty
   a_mux_range: assert property (p_mux_range) else $error("absent channel selected");

   property p_mux_se;
      @(posedge clock) disable iff (rst)
      (state_reg != ST_CONV && cfg.single_ended_select) |=> mux.neg_gnd && mux.neg == '0;
   endproperty
   a_mux_se: assert property (p_mux_se) else $error("single-ended not ground referenced");
endmodule // adcs_seq

/* File: adcs_master_model.sv */
// Bus master model: drives the serial clock and marks the address byte
`timescale 1ns/10ps
module adcs_master_model (
   // Clock and observed wire
   input wire logic clock,
   input wire logic scl_line,
   // Master drive
   output logic scl_m,
   output logic addr_start
);
   // Stretches that never ended; the bench checks this stays zero
   int timeouts;

   // Clock idles high between frames; the pull-up keeps the wire high
   initial begin
      scl_m = 1'b1;
      addr_start = 1'b0;
      timeouts = 0;
   end

   // One frame: start mark, then a number of falling clock edges
   task automatic frame(input int falls);
      int w;
      @(posedge clock);
      #4 addr_start = 1'b1;
      @(posedge clock);
      #4 addr_start = 1'b0;
      #160;
      for (int i = 0; i < falls; i++) begin
         scl_m = 1'b0;
         // Last low phase is long so the stretch is seen before release
         #((i == falls - 1) ? 480 : 160);
         scl_m = 1'b1;
         w = 0;
         // Honour clock stretching, but never wait forever
         while (scl_line !== 1'b1 && w < 2000) begin
            #40;
            w++;
         end
         if (w >= 2000) timeouts++;
         #160;
      end
   endtask
endmodule // adcs_master_model

/* File: adcs_seq_tb.sv */
// Self-checking testbench for the track/hold sequencer
`timescale 1ns/10ps
module adcs_seq_tb;
   import adcs_pkg::*;
   localparam int NCH = 8;
   logic clock, rst, scl_m, addr_start, addr_match, cmp_high, scl_out, scl_oe_n;
   logic result_valid, busy, track, scl_line;
   adcs_cfg_t cfg;
   adcs_mux_t mux;
   logic [7:0] dac_trial, result, ain, got;
   int fails, check_count, nres, trk_len, trk_cnt, trk_rise, str_cnt, bsy_cnt;

   // Open-drain wire: low when either party pulls it
   assign scl_line = scl_m & (scl_oe_n ? 1'b1 : scl_out);
   // Ideal comparator against a fixed analog level
   assign cmp_high = (ain >= dac_trial);

   adcs_seq #(.NUM_CH(NCH)) i_adcs_seq (.clock(clock), .rst(rst), .scl_in(scl_line), .scl_out(scl_out),
      .scl_oe_n(scl_oe_n), .addr_start(addr_start), .addr_match(addr_match), .cfg(cfg), .cmp_high(cmp_high),
      .dac_trial(dac_trial), .track(track), .mux(mux), .result(result), .result_valid(result_valid), .busy(busy));
   adcs_master_model i_adcs_master_model (.clock(clock), .scl_line(scl_line), .scl_m(scl_m),
      .addr_start(addr_start));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // Monitor at the falling edge so registered outputs have settled
   always @(negedge clock) begin
      if (result_valid === 1'b1) begin
         got = result;
         nres++;
      end
      if (track === 1'b1) begin
         if (trk_cnt == 0) trk_rise++;
         trk_cnt++;
      end else if (trk_cnt != 0) begin
         trk_len = trk_cnt;
         trk_cnt = 0;
      end
      if (scl_oe_n === 1'b0) str_cnt++;
      if (busy === 1'b1) bsy_cnt++;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
         fails++;
      end
   endtask

   task automatic end_of_test;
      $display("Counts: %0d mismatches in %0d comparisons", fails, check_count);
      if (fails == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Expected routing; the shared pin is the top channel when it serves as reference
   function automatic adcs_mux_t exp_mux(input logic se, input logic [2:0] rs, input logic [3:0] ch);
      adcs_mux_t m;
      m = '0;
      m.neg_gnd = se;
      m.shared_pin_is_ref = rs[REF_PIN_SEL_BIT];
      if (ch < NCH && !(rs[REF_PIN_SEL_BIT] && (ch == NCH - 1 || (!se && (ch ^ 4'h1) == NCH - 1)))) begin
         m.pos[ch] = 1'b1;
         if (!se) m.neg[ch ^ 4'h1] = 1'b1;
      end
      return m;
   endfunction

   // One address byte with conversions; k is the number of results expected
   task automatic run(input logic ext, input logic se, input logic bip, input logic [3:0] scan,
      input logic [7:0] a, input int k);
      int n0;
      logic [7:0] e;
      @(posedge clock);
      #4 cfg.ext_clock = ext;
      cfg.single_ended_select = se;
      cfg.bipolar_select = bip;
      cfg.scan_count = scan;
      ain = a;
      addr_match = 1'b1;
      n0 = nres;
      trk_rise = 0;
      str_cnt = 0;
      bsy_cnt = 0;
      e = (bip && !se) ? (a ^ BIP_FLIP) : a;
      i_adcs_master_model.frame(ext ? 16 : 9);
      for (int i = 0; i < 800 && nres < n0 + k; i++) @(posedge clock);
      if (nres < n0 + k) begin
         $display("Error at %0t: no result in time", $time);
         fails++;
      end
      // Let busy fall before looking at it
      repeat (2) @(negedge clock);
      chk(nres - n0, k);
      chk(i_adcs_master_model.timeouts, 0);
      chk(bsy_cnt > 0, 1'b1);
      chk(busy, 1'b0);
      chk(got, e);
      chk(trk_rise, k);
      if (ext) begin
         chk(str_cnt, 0);
         chk(trk_len >= 7 && trk_len <= 9, 1'b1);
      end else begin
         chk(trk_len >= OSC_DIV && trk_len <= 2 * OSC_DIV + 1, 1'b1);
         chk(str_cnt >= (10 * k - 1) * OSC_DIV && str_cnt <= 10 * k * OSC_DIV + 4, 1'b1);
         chk(scl_oe_n, 1'b1);
      end
   endtask

   // Overall hang guard
   initial begin
      #2000000;
      $display("Error at %0t: run timed out", $time);
      fails++;
      end_of_test();
   end

   initial begin
      fails = 0;
      check_count = 0;
      nres = 0;
      trk_cnt = 0;
      trk_len = 0;
      trk_rise = 0;
      str_cnt = 0;
      bsy_cnt = 0;
      rst = 1'b1;
      cfg = '0;
      ain = 8'h00;
      addr_match = 1'b0;
      repeat (2) @(posedge clock);
      #4 rst = 1'b0;
      chk(scl_oe_n, 1'b1);
      chk(track, 1'b0);
      chk(scl_out, 1'b0);
      chk(busy, 1'b0);
      // Every channel code, both input modes, shared pin as input and as reference
      for (int s = 0; s < 2; s++) begin
         for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 16; c++) begin
               @(posedge clock);
               #4 cfg.single_ended_select = s[0];
               cfg.ref_sel = r[0] ? 3'h2 : 3'h0;
               cfg.channel_sel = c[3:0];
               repeat (3) @(posedge clock);
               #4 chk(mux, exp_mux(s[0], cfg.ref_sel, c[3:0]));
            end
         end
      end
      cfg.ref_sel = 3'h0;
      cfg.channel_sel = 4'h1;
      // A scan count of zero still makes one conversion
      run(1'b0, 1'b1, 1'b0, 4'h0, 8'ha5, 1);
      run(1'b0, 1'b0, 1'b1, 4'h2, 8'h3c, 2);
      run(1'b1, 1'b0, 1'b1, 4'h1, 8'h3c, 1);
      run(1'b1, 1'b1, 1'b1, 4'h1, 8'hff, 1);
      // Address that does not match: no track, no result
      @(posedge clock);
      #4 addr_match = 1'b0;
      trk_rise = 0;
      bsy_cnt = 0;
      str_cnt = nres;
      i_adcs_master_model.frame(16);
      repeat (20) @(posedge clock);
      chk(trk_rise, 0);
      chk(bsy_cnt, 0);
      chk(nres, str_cnt);
      end_of_test();
   end
endmodule // adcs_seq_tb
